// >>> core/etc_pkg.sv
`default_nettype none
package etc_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] ETC_OFS_RUN = 8'h00;
  localparam logic [7:0] ETC_OFS_CHA = 8'h04;
  localparam logic [7:0] ETC_OFS_CHB = 8'h08;
  localparam logic [7:0] ETC_OFS_CNT = 8'h0C;
  localparam logic [7:0] ETC_OFS_CMPA = 8'h10;
  localparam logic [7:0] ETC_OFS_CMPB = 8'h14;
  // Field positions in the run and channel control registers.
  localparam int ETC_RUN_BIT = 3;
  localparam int ETC_MODE_POS = 6;
  localparam int ETC_ACT_POS = 4;
  localparam int ETC_INIT_BIT = 3;
  localparam int ETC_POL_BIT = 2;
  localparam int ETC_DIR_BIT = 1;
  localparam int ETC_CLR_BIT = 0;
  localparam int ETC_ALIGN_POS = 0;
  // Values after reset.
  localparam logic [7:0] ETC_CTL_RST = 8'h00;
  localparam logic [9:0] ETC_CNT_RST = 10'h000;
  // Counting clock is the bus clock divided by four; this is the last divider count.
  localparam logic [1:0] ETC_TICK_LAST = 2'h3;
  localparam logic [9:0] ETC_CNT_MAX = 10'h3FF;
  localparam logic [1:0] ETC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ETC_RESP_DECERR = 2'h3;
  // Channel operating modes.
  typedef enum logic [1:0] {
    ETC_M_CMP = 2'h0,
    ETC_M_CAP = 2'h1,
    ETC_M_PWM = 2'h2,
    ETC_M_TMR = 2'h3
  } etc_mode_t;
  // Counting direction state, one-hot.
  typedef enum logic [1:0] {
    ETC_UP = 2'h1,
    ETC_DN = 2'h2
  } etc_dir_t;

  // True for an address that holds a register.
  function automatic logic etc_hit(input logic [7:0] a);
    etc_hit = (a == ETC_OFS_RUN) || (a == ETC_OFS_CHA) ||
      (a == ETC_OFS_CHB) || (a == ETC_OFS_CNT) ||
      (a == ETC_OFS_CMPA) || (a == ETC_OFS_CMPB);
  endfunction : etc_hit

  // Merges write data into a register under its byte strobes.
  function automatic logic [9:0] etc_merge(input logic [9:0] o,
    input logic [31:0] w, input logic [3:0] s);
    etc_merge = {s[1] ? w[9:8] : o[9:8], s[0] ? w[7:0] : o[7:0]};
  endfunction : etc_merge

  // Capture edge test for one pin: 0 rise, 1 fall, 2 both, 3 off.
  function automatic logic etc_edge(input logic [1:0] act,
    input logic old, input logic now);
    case (act)
      2'h0: etc_edge = !old && now;
      2'h1: etc_edge = old && !now;
      2'h2: etc_edge = old != now;
      default: etc_edge = 1'b0;
    endcase
  endfunction : etc_edge
endpackage : etc_pkg
`default_nettype wire

// >>> core/etc_reg_if.sv
`default_nettype none
// Register access strobes between the bus slave and the register file.
interface etc_reg_if;
  logic we;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic werr;
  logic [7:0] raddr;
  logic [31:0] rdata;
  logic rerr;
  modport slv (output we, waddr, wdata, wstrb, raddr,
    input werr, rdata, rerr);
  modport regs (input we, waddr, wdata, wstrb, raddr,
    output werr, rdata, rerr);
endinterface : etc_reg_if
`default_nettype wire

// >>> core/etc_axil.sv
`default_nettype none
module etc_axil (
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  etc_reg_if.slv bus // Register file side.
);
  import etc_pkg::*;

  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic aw_v;
    logic w_v;
    logic [7:0] aa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic we;
    logic bv;
    logic [1:0] br;
    logic arrdy;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } etc_axs_t;

  etc_axs_t s_q;
  etc_axs_t s_d;

  // Address and data are held until both are in, then one write issues.
  always_comb begin
    s_d = s_q;
    s_d.we = 1'b0;
    if (awvalid && s_q.awrdy) begin
      s_d.aw_v = 1'b1;
      s_d.aa = awaddr;
    end
    if (wvalid && s_q.wrdy) begin
      s_d.w_v = 1'b1;
      s_d.wd = wdata;
      s_d.ws = wstrb;
    end
    if (s_q.aw_v && s_q.w_v && !s_q.bv) begin
      s_d.we = 1'b1;
      s_d.bv = 1'b1;
      s_d.br = bus.werr ? ETC_RESP_DECERR : ETC_RESP_OKAY;
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
    end
    if (s_q.bv && bready) begin
      s_d.bv = 1'b0;
    end
    s_d.awrdy = !s_d.aw_v && !s_d.bv;
    s_d.wrdy = !s_d.w_v && !s_d.bv;
    if (arvalid && s_q.arrdy) begin
      s_d.rv = 1'b1;
      s_d.rd = bus.rdata;
      s_d.rr = bus.rerr ? ETC_RESP_DECERR : ETC_RESP_OKAY;
    end
    if (s_q.rv && rready) begin
      s_d.rv = 1'b0;
    end
    s_d.arrdy = !s_d.rv;
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come from the state register; reads decode the live address.
  assign awready = s_q.awrdy;
  assign wready = s_q.wrdy;
  assign bvalid = s_q.bv;
  assign bresp = s_q.br;
  assign arready = s_q.arrdy;
  assign rvalid = s_q.rv;
  assign rdata = s_q.rd;
  assign rresp = s_q.rr;
  assign bus.we = s_q.we;
  assign bus.waddr = s_q.aa;
  assign bus.wdata = s_q.wd;
  assign bus.wstrb = s_q.ws;
  assign bus.raddr = araddr;
endmodule : etc_axil
`default_nettype wire

// >>> core/etc_chan.sv
`default_nettype none
module etc_chan (
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire etc_pkg::etc_mode_t mode, // Channel operating mode.
  input wire logic [1:0] act, // Output action or capture edge.
  input wire logic init, // Initial level or active level.
  input wire logic pol, // Final output inversion.
  input wire logic run, // Counter run bit.
  input wire logic run_rise, // Run bit went from zero to one.
  input wire logic match, // Own comparator match, one cycle.
  input wire logic pwm_lvl, // Waveform is in its active phase.
  input wire logic [2:0] pin_in, // Pin levels seen from outside.
  output logic pin_out, // Pin drive level.
  output logic pin_oe, // Pin drive enable.
  output logic cap // Capture event, one cycle.
);
  import etc_pkg::*;

  typedef struct packed {
    logic lvl;
    logic out;
    logic oe;
    logic [2:0] old;
    logic cap;
  } etc_chs_t;

  etc_chs_t s_q;
  etc_chs_t s_d;
  logic raw;

  // Mode decode drives the pin, or watches it for capture edges.
  always_comb begin
    s_d = s_q;
    s_d.old = pin_in;
    s_d.cap = 1'b0;
    raw = 1'b0;
    case (mode)
      ETC_M_CMP: begin
        if (run_rise) begin
          s_d.lvl = init;
        end else if (match) begin
          // A set to the level already held shows no change.
          case (act)
            2'h1: s_d.lvl = 1'b0;
            2'h2: s_d.lvl = 1'b1;
            2'h3: s_d.lvl = !s_q.lvl;
            default: s_d.lvl = s_q.lvl;
          endcase
        end
        raw = s_d.lvl;
      end
      ETC_M_PWM: begin
        // The initial-level bit names the active level here.
        case (act)
          2'h0: raw = !init;
          2'h1: raw = init;
          2'h2: raw = pwm_lvl ? init : !init;
          default: raw = run ? init : !init;
        endcase
      end
      ETC_M_CAP: begin
        s_d.cap = etc_edge(act, s_q.old[0], pin_in[0]) ||
          etc_edge(act, s_q.old[1], pin_in[1]) ||
          etc_edge(act, s_q.old[2], pin_in[2]);
      end
      default: raw = 1'b0;
    endcase
    s_d.oe = (mode == ETC_M_CMP) || (mode == ETC_M_PWM);
    s_d.out = s_d.oe ? raw ^ pol : 1'b0;
  end

  // State register; reset leaves the pin undriven and low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.out;
  assign pin_oe = s_q.oe;
  assign cap = s_q.cap;
endmodule : etc_chan
`default_nettype wire

// >>> core/etc_top.sv
// Functional notes
// - Run rise clears counter; fall holds and sleeps.
// - Run rise restores compare pin initial level.
// - Period code against counter top bits.
// - Period code zero: overflow clears the counter.
// - Channel A mode field decodes four modes.
// - Channel B mode field decodes like A.
// - Channel A match applies output action.
// - PWM action: inactive, active, PWM, pulse.
// - Capture action selects edge or disables.
// - Setting the held level shows no change.
// - Compare mode initial-level bit sets pin.
// - PWM mode initial-level bit is active level.
// - Polarity bit inverts pin except timer, capture.
// - Read-only flag shows counting direction.
// - Clear source: A match, or period.
// - Clear source ignored in pulse, capture.
// - Channel B settings drive three pins.
// - B match moves B pins; period never.
// - Ten-bit up/down counter, full compares.
`default_nettype none
module etc_top (
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic chan_a_pin_in, // Channel A pin level.
  output logic chan_a_pin_out, // Channel A pin drive.
  output logic chan_a_pin_oe, // Channel A pin enable.
  input wire logic [2:0] chan_b_pin_in, // Channel B pin levels.
  output logic [2:0] chan_b_pin_out, // Channel B pin drives.
  output logic [2:0] chan_b_pin_oe // Channel B pin enables.
);
  import etc_pkg::*;

  typedef struct packed {
    logic run;
    logic run_old;

    logic [2:0] psel;
    logic [7:0] a_ctl;
    logic [7:0] b_ctl;

    logic [9:0] cnt;
    etc_dir_t dir;

    logic [9:0] cmp_a;
    logic [9:0] cmp_b;
    logic [9:0] sh_a;
    logic [9:0] sh_b;

    logic [1:0] div;
    logic tick;
  } etc_tops_t;

  etc_tops_t s_q;
  etc_tops_t s_d;

  etc_reg_if bus ();

  // Decoded control fields.
  etc_mode_t mode_a;
  etc_mode_t mode_b;
  logic run_rise;
  logic up;

  // Comparator results.
  logic [9:0] nxt;
  logic p_hit;
  logic ovf;
  logic a_m;
  logic b_m;

  logic spm;
  logic cap_md;
  logic ctr;
  logic top_evt;
  logic turn_bot;
  logic load;
  logic [1:0] align;

  // Waveform and capture.
  logic pwm_a;
  logic pwm_b;
  logic cap_a;
  logic cap_b;

  // Channel pin flops.
  logic a_out;
  logic a_oe;
  logic b_out;
  logic b_oe;

  logic [9:0] m;

  // Bus slave; it owns every AXI4-Lite output.
  etc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .bus(bus.slv)
  );

  // Mode fields of both channel control registers; alignment from B.
  assign mode_a = etc_mode_t'(s_q.a_ctl[ETC_MODE_POS+:2]);
  assign mode_b = etc_mode_t'(s_q.b_ctl[ETC_MODE_POS+:2]);
  assign align = s_q.b_ctl[ETC_ALIGN_POS+:2];

  assign run_rise = s_q.run && !s_q.run_old;
  assign up = s_q.dir != ETC_DN;

  // Comparators: period on the top three bits, A and B on all ten.
  always_comb begin
    nxt = s_q.cnt + 10'h001;
    p_hit = (s_q.psel != 3'h0) && (nxt[9:7] == s_q.psel) &&
      (nxt[6:0] == 7'h00);
    ovf = (s_q.psel == 3'h0) && (s_q.cnt == ETC_CNT_MAX);
    a_m = s_q.tick && (s_q.cnt == s_q.cmp_a);
    b_m = s_q.tick && (s_q.cnt == s_q.cmp_b);
  end

  // Counter clearing source and alignment, steered by channel A mode.
  always_comb begin
    spm = (mode_a == ETC_M_PWM) && (s_q.a_ctl[ETC_ACT_POS+:2] == 2'h3);
    cap_md = mode_a == ETC_M_CAP;
    ctr = (mode_a == ETC_M_PWM) && !spm && (align != 2'h0);

    if (s_q.a_ctl[ETC_CLR_BIT] && !spm && !cap_md) begin
      top_evt = a_m && up;
    end else begin
      top_evt = s_q.tick && up && !spm && (p_hit || ovf);
    end
    turn_bot = s_q.tick && !up && (s_q.cnt == 10'h001);

    // Shadows reload at the edges that the alignment picks.
    case (align)
      2'h0: load = top_evt;
      2'h1: load = turn_bot;
      2'h2: load = top_evt;
      default: load = turn_bot || top_evt;
    endcase
    load = load || !s_q.run;

    pwm_a = s_q.cnt < s_q.sh_a;
    pwm_b = s_q.cnt < s_q.sh_b;
  end

  // Register writes, counting, capture and the pulse end.
  always_comb begin
    s_d = s_q;
    m = 10'h000;

    s_d.run_old = s_q.run;
    s_d.tick = 1'b0;
    if (s_q.run && !run_rise) begin
      s_d.div = s_q.div + 2'h1;
      s_d.tick = s_q.div == ETC_TICK_LAST;
    end

    if (run_rise) begin
      s_d.cnt = ETC_CNT_RST;
      s_d.dir = ETC_UP;
      s_d.div = 2'h0;
    end else if (s_q.tick) begin
      case (s_q.dir)
        ETC_UP: begin
          if (top_evt && ctr) begin
            s_d.dir = ETC_DN;
            s_d.cnt = s_q.cnt - 10'h001;
          end else if (top_evt) begin
            s_d.cnt = ETC_CNT_RST;
          end else begin
            s_d.cnt = nxt;
          end
        end
        ETC_DN: begin
          s_d.cnt = s_q.cnt - 10'h001;
          if (turn_bot) begin
            s_d.dir = ETC_UP;
          end
        end
        default: s_d.dir = ETC_UP;
      endcase
    end

    if (load) begin
      s_d.sh_a = s_q.cmp_a;
      s_d.sh_b = s_q.cmp_b;
    end

    // A single pulse ends when channel A matches.
    if (spm && a_m) begin
      s_d.run = 1'b0;
    end

    if (bus.we) begin
      m = etc_merge({2'h0, s_q.a_ctl}, bus.wdata, bus.wstrb);
      case (bus.waddr)
        ETC_OFS_RUN: begin
          m = etc_merge({6'h00, s_q.run, s_q.psel}, bus.wdata,
            bus.wstrb);
          s_d.run = m[ETC_RUN_BIT];
          s_d.psel = m[2:0];
        end
        ETC_OFS_CHA: begin
          s_d.a_ctl = m[7:0];
          s_d.a_ctl[ETC_DIR_BIT] = 1'b0;
        end
        ETC_OFS_CHB: begin
          m = etc_merge({2'h0, s_q.b_ctl}, bus.wdata, bus.wstrb);
          s_d.b_ctl = m[7:0];
        end
        ETC_OFS_CMPA: begin
          s_d.cmp_a = etc_merge(s_q.cmp_a, bus.wdata, bus.wstrb);
        end
        ETC_OFS_CMPB: begin
          s_d.cmp_b = etc_merge(s_q.cmp_b, bus.wdata, bus.wstrb);
        end
        default: m = 10'h000;
      endcase
    end

    // A capture wins over a write in the same cycle.
    if (cap_a) begin
      s_d.cmp_a = s_q.cnt;
    end
    if (cap_b) begin
      s_d.cmp_b = s_q.cnt;
    end
  end

  // State register; all control fields start at zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.dir <= ETC_UP;
    end else begin
      s_q <= s_d;
    end
  end

  // Read data and decode errors for the bus slave.
  always_comb begin
    bus.rdata = 32'h0000_0000;
    bus.rerr = !etc_hit(bus.raddr);
    bus.werr = !etc_hit(bus.waddr);

    case (bus.raddr)
      ETC_OFS_RUN: bus.rdata[3:0] = {s_q.run, s_q.psel};
      ETC_OFS_CHA: begin
        bus.rdata[7:0] = s_q.a_ctl;
        bus.rdata[ETC_DIR_BIT] = s_q.dir == ETC_DN;
      end
      ETC_OFS_CHB: bus.rdata[7:0] = s_q.b_ctl;
      ETC_OFS_CNT: bus.rdata[9:0] = s_q.cnt;
      ETC_OFS_CMPA: bus.rdata[9:0] = s_q.cmp_a;
      ETC_OFS_CMPB: bus.rdata[9:0] = s_q.cmp_b;
      default: bus.rdata = 32'h0000_0000;
    endcase
  end

  // Channel A pin logic.
  etc_chan u_chan_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode_a),
    .act(s_q.a_ctl[ETC_ACT_POS+:2]),
    .init(s_q.a_ctl[ETC_INIT_BIT]),
    .pol(s_q.a_ctl[ETC_POL_BIT]),
    .run(s_q.run),
    .run_rise(run_rise),
    .match(a_m),
    .pwm_lvl(pwm_a),
    .pin_in({2'h0, chan_a_pin_in}),
    .pin_out(a_out),
    .pin_oe(a_oe),
    .cap(cap_a)
  );

  // Channel B pin logic, shared by its three pins.
  etc_chan u_chan_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode_b),
    .act(s_q.b_ctl[ETC_ACT_POS+:2]),
    .init(s_q.b_ctl[ETC_INIT_BIT]),
    .pol(s_q.b_ctl[ETC_POL_BIT]),
    .run(s_q.run),
    .run_rise(run_rise),
    .match(b_m),
    .pwm_lvl(pwm_b),
    .pin_in(chan_b_pin_in),
    .pin_out(b_out),
    .pin_oe(b_oe),
    .cap(cap_b)
  );

  // Pin outputs are the channel flip-flops, fanned out for B.
  assign chan_a_pin_out = a_out;
  assign chan_a_pin_oe = a_oe;
  assign chan_b_pin_out = {3{b_out}};
  assign chan_b_pin_oe = {3{b_oe}};
endmodule : etc_top
`default_nettype wire

// >>> bench/etc_top_sva.sv
`default_nettype none
module etc_top_sva (
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic chan_a_pin_out, // Channel A pin drive.
  input wire logic chan_a_pin_oe, // Channel A pin enable.
  input wire logic [2:0] chan_b_pin_out, // Channel B pin drives.
  input wire logic [2:0] chan_b_pin_oe // Channel B pin enables.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both halves of a write taken, and a read address taken.
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Reset leaves the bus idle and every pin released.
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !chan_a_pin_oe && chan_b_pin_oe == 3'h0)
    else $error("outputs active after reset");
  write_answer_a: assert property (aw_w_taken |=> ##1 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  write_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  pins_b_copies_a: assert property (
    chan_b_pin_out == {3{chan_b_pin_out[0]}} &&
    chan_b_pin_oe == {3{chan_b_pin_oe[0]}}) else $error("B pins differ");
  idle_pin_low_a: assert property (!chan_a_pin_oe |-> !chan_a_pin_out)
    else $error("released pin driven");
endmodule : etc_top_sva
bind etc_top etc_top_sva chk (.*);
`default_nettype wire

// >>> bench/etc_pin_model.sv
`default_nettype none
module etc_pin_model (
  input wire logic ext_a, // Far side level on pin A.
  input wire logic [2:0] ext_b, // Far side levels on B pins.
  input wire logic a_out, // Block drive on pin A.
  input wire logic a_oe, // Block enable on pin A.
  input wire logic [2:0] b_out, // Block drives on B pins.
  input wire logic [2:0] b_oe, // Block enables on B pins.
  output logic a_lvl, // Wire level of pin A.
  output logic [2:0] b_lvl // Wire levels of B pins.
);
  timeunit 1ns;
  timeprecision 1ps;
  // A pin driven by the block follows it; a released pin shows the far side.
  assign a_lvl = a_oe ? a_out : ext_a;
  assign b_lvl = (b_oe & b_out) | (~b_oe & ext_b);
endmodule : etc_pin_model
`default_nettype wire

// >>> bench/etc_top_test.sv
`default_nettype none
module etc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import etc_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pol;
  logic awready, wready, bvalid, arready, rvalid, a_out, a_oe, a_lvl, ext_a;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got, r, va, vb;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, al, e;
  logic [2:0] b_out, b_oe, b_lvl, ext_b;
  logic [65:0] note;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  int fails, samples_checked;

  etc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(ws), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chan_a_pin_in(a_lvl), .chan_a_pin_out(a_out),
    .chan_a_pin_oe(a_oe), .chan_b_pin_in(b_lvl), .chan_b_pin_out(b_out),
    .chan_b_pin_oe(b_oe));
  etc_pin_model far (.ext_a(ext_a), .ext_b(ext_b), .a_out(a_out),
    .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .a_lvl(a_lvl), .b_lvl(b_lvl));

  // Free-running bus clock.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  // Ends the run when a handshake never completes.
  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      fails++;
      summarize();
    end
  endtask : guard

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er = ETC_RESP_OKAY);
    int n;
    logic ap, dp;
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    ap = 1'b1;
    dp = 1'b1;
    while (ap || dp) begin
      @(posedge aclk);
      if (ap && awready) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (dp && wready) begin
        dp = 1'b0;
        wvalid <= 1'b0;
      end
      guard(n);
    end
    repeat ($urandom_range(2)) @(posedge aclk);
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  // A mask of zero records the read without checking its data.
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] er = 2'h0);
    int n;
    rq.push_back({er, x, m});
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!arready);
    arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!rvalid);
    got = rdata;
    rready <= 1'b0;
  endtask : rd

  // Compares each bus answer with the oldest expectation noted.
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      note = rq.pop_front();
      cmp({30'h0, rresp}, {30'h0, note[65:64]});
      cmp(rdata & note[31:0], note[63:32]);
    end
    if (bvalid && bready) cmp({30'h0, bresp}, {30'h0, bq.pop_front()});
  end

  task automatic pins(input logic v);
    cmp({24'h0, a_oe, a_out, b_oe, b_out}, {24'h0, 1'b1, v, 3'h7, {3{v}}});
  endtask : pins

  // Counter must sit within four ticks of x modulo the period.
  task automatic near(input int per, input int x);
    int d;
    rd(ETC_OFS_CNT, 32'h0, 32'h0);
    d = (int'(got[9:0]) + per - x % per) % per;
    cmp({31'h0, d <= 4 || d >= per - 4}, 32'h1);
  endtask : near

  // Pin levels before and after the first match, polarity aside.
  function automatic logic [1:0] pexp(input int md, input int ac,
    input logic ini);
    if (md == 0)
      pexp = {ini, ac == 0 ? ini : ac == 1 ? 1'b0 : ac == 2 ? 1'b1 : !ini};
    else
      pexp = ac == 0 ? {2{!ini}} : ac == 1 ? {2{ini}} : {ini, !ini};
  endfunction : pexp

  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_a} = 7'h0;
    {awaddr, araddr, wdata, ext_b} = 51'h0;
    ws = 4'hF;
    fails = 0;
    samples_checked = 0;
    void'($urandom(77467));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
    rd(8'h18, 32'h0, 32'hFFFF_FFFF, ETC_RESP_DECERR);
    wr(8'h18, 32'hFF, ETC_RESP_DECERR);
    r = $urandom;
    wr(ETC_OFS_CHA, r);
    rd(ETC_OFS_CHA, r & 32'hFD, 32'hFF);
    wr(ETC_OFS_CHB, ~r);
    rd(ETC_OFS_CHB, ~r & 32'hFF, 32'hFF);
    ws <= 4'h1;
    wr(ETC_OFS_CMPA, 32'h3AB);
    ws <= 4'hF;
    rd(ETC_OFS_CMPA, 32'h0AB);
    // Compare and waveform modes, each action and level.
    wr(ETC_OFS_CMPA, 32'h5);
    wr(ETC_OFS_CMPB, 32'h7);
    for (int m = 0; m < 4; m += 2) for (int a = 0; a < 4; a++)
      for (int i = 0; i < 2; i++) begin
        pol = 1'($urandom);
        al = 2'($urandom);
        e = pexp(m, a, i[0]) ^ {2{pol}};
        wr(ETC_OFS_RUN, 32'h0);
        wr(ETC_OFS_CHA, {24'h0, m[1:0], a[1:0], i[0], pol, 2'h0});
        wr(ETC_OFS_CHB, {24'h0, m[1:0], a[1:0], i[0], pol, al});
        wr(ETC_OFS_RUN, 32'h9);
        repeat (6) @(posedge aclk);
        pins(e[1]);
        repeat (150) @(posedge aclk);
        pins(e[0]);
      end
    // Timer mode keeps every pin released.
    wr(ETC_OFS_RUN, 32'h0);
    wr(ETC_OFS_CHA, 32'hFC);
    wr(ETC_OFS_CHB, 32'hFC);
    wr(ETC_OFS_RUN, 32'h8);
    repeat (4) @(posedge aclk);
    cmp({24'h0, a_oe, a_out, b_oe, b_out}, 32'h0);
    // Every period code, clearing on the period comparator, or on overflow for code zero.
    wr(ETC_OFS_CHA, 32'h0);
    for (int p = 0; p < 8; p++) begin
      wr(ETC_OFS_RUN, 32'h0);
      wr(ETC_OFS_RUN, 32'(8 + p));
      repeat (1100) @(posedge aclk);
      wr(ETC_OFS_RUN, 32'h0);
      near(p == 0 ? 1024 : p * 128, 276);
    end
    // Clearing on the channel A comparator while counting up.
    wr(ETC_OFS_CMPA, 32'd40);
    wr(ETC_OFS_CHA, 32'h1);
    wr(ETC_OFS_RUN, 32'h8);
    repeat (1100) @(posedge aclk);
    rd(ETC_OFS_CHA, 32'h0, 32'h2);
    wr(ETC_OFS_RUN, 32'h0);
    near(41, 277);
    // Capture on each edge choice, on pin A and one B pin.
    for (int a = 0; a < 4; a++) begin
      r = 32'(1 << $urandom_range(2));
      wr(ETC_OFS_RUN, 32'h0);
      wr(ETC_OFS_CMPA, 32'h3FF);
      wr(ETC_OFS_CMPB, 32'h3FF);
      wr(ETC_OFS_CHA, {24'h0, 2'h1, a[1:0], 4'h1});
      wr(ETC_OFS_CHB, {24'h0, 2'h1, a[1:0], 4'h0});
      wr(ETC_OFS_RUN, 32'h8);
      repeat (20) @(posedge aclk);
      ext_a <= 1'b1;
      ext_b <= r[2:0];
      repeat (20) @(posedge aclk);
      rd(ETC_OFS_CMPA, 32'h0, 32'h0);
      va = got;
      cmp({31'h0, va === 32'h3FF}, {31'h0, a[0]});
      rd(ETC_OFS_CMPB, 32'h0, 32'h0);
      vb = got;
      cmp({31'h0, vb === 32'h3FF}, {31'h0, a[0]});
      ext_a <= 1'b0;
      ext_b <= 3'h0;
      repeat (20) @(posedge aclk);
      rd(ETC_OFS_CMPA, 32'h0, 32'h0);
      cmp({31'h0, got === va}, {31'h0, a[1] == a[0]});
      rd(ETC_OFS_CMPB, 32'h0, 32'h0);
      cmp({31'h0, got === vb}, {31'h0, a[1] == a[0]});
    end
    summarize();
  end
endmodule : etc_top_test
`default_nettype wire
